// ==== inc/exec_pkg.sv ====
`default_nettype none
package exec_pkg;
  // instruction encodings (14-bit)
  localparam logic [13:0] KICK_WORD = 14'h0064;
  localparam logic [5:0] INVERT_CODE = 6'h09;
  localparam logic [5:0] DECR_CODE = 6'h03;
  localparam logic [5:0] DECR_SKIP_CODE = 6'h0B;
  localparam logic [5:0] INCR_CODE = 6'h0A;
  localparam logic [5:0] INCR_SKIP_CODE = 6'h0F;
  localparam logic [2:0] JUMP_CODE = 3'h5;
  localparam logic [5:0] OR_LIT_CODE = 6'h38;
  localparam logic [13:0] NOP_WORD = 14'h0000;
  // field positions
  localparam int DEST_BIT = 7;
  localparam int LATCH_LO = 3;
  // register bus offsets
  localparam logic [7:0] INSTR_OFS = 8'h00;
  localparam logic [7:0] ACC_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] PC_OFS = 8'h0C;
  localparam logic [7:0] LATCH_OFS = 8'h10;
  localparam logic [7:0] FILE_ADDR_OFS = 8'h14;
  localparam logic [7:0] FILE_DATA_OFS = 8'h18;
  localparam logic [7:0] WDOG_OFS = 8'h1C;
  // status bit positions
  localparam int ZERO_POS = 0;
  localparam int SLEEP_POS = 1;
  localparam int EXPIRY_POS = 2;
  // reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [2:0] STATUS_RESET = 3'h6;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [6:0] FILE_ADDR_RESET = 7'h00;
  localparam int FILE_DEPTH = 128;
  localparam int WDOG_COUNT_W = 8;
  localparam int WDOG_PRESCALE_W = 8;
endpackage
`default_nettype wire

// ==== inc/file_port_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface file_port_if;
  logic [6:0] addr;
  logic [7:0] rdata;
  logic we;
  logic [7:0] wdata;
  modport user (output addr, output we, output wdata, input rdata);
  modport store (input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire

// ==== logic/file_store.sv ====
`timescale 1ns/1ps
`default_nettype none
module file_store
  import exec_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  file_port_if.store fp
);
  logic [7:0] mem [FILE_DEPTH];
  logic [7:0] next_mem [FILE_DEPTH];

  always_comb begin
    next_mem = mem;
    if (fp.we) begin
      next_mem[fp.addr] = fp.wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        mem[i] <= 8'h00;
      end
    end else begin
      mem <= next_mem;
    end
  end

  assign fp.rdata = mem[fp.addr];
endmodule // file_store
`default_nettype wire

// ==== logic/watchdog_stub.sv ====
`timescale 1ns/1ps
`default_nettype none
module watchdog_stub
  import exec_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic kick,
  output logic [WDOG_COUNT_W-1:0] count,
  output logic [WDOG_PRESCALE_W-1:0] prescale
);
  logic [WDOG_COUNT_W-1:0] next_count;
  logic [WDOG_PRESCALE_W-1:0] next_prescale;

  // free-running prescaler; counter advances when it wraps
  always_comb begin
    next_prescale = prescale + 8'h01;
    next_count = (prescale == 8'hFF) ? count + 8'h01 : count;
    if (kick) begin
      next_prescale = 8'h00;
      next_count = 8'h00;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 8'h00;
      prescale <= 8'h00;
    end else begin
      count <= next_count;
      prescale <= next_prescale;
    end
  end
endmodule // watchdog_stub
`default_nettype wire

// ==== logic/instruction_subset_exec.sv ====
// Notes on behaviour
// - kick opcode clears watchdog counter and prescaler in one cycle.
// - kick sets expiry and sleep-entered status bits, other flags untouched.
// - destination bit 0 writes accumulator, 1 writes file register.
// - invert-file complements register to destination, updates zero flag only.
// - decrement-file subtracts one to destination and updates zero flag.
// - decrement-skip subtracts one, skips on zero, flags unchanged.
// - increment-skip adds one, skips on zero, flags unchanged.
// - a taken skip discards the prefetched word and runs a no-operation.
// - increment-file adds one modulo 256 and updates zero flag.
// - jump loads literal into pc low bits, latch bits 4:3 into pc 12:11.
// - jump takes two cycles, flushing prefetch, no flag change.
// - or-literal ORs literal into accumulator and updates zero flag.
//
// Decided for this implementation: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module instruction_subset_exec
  import exec_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  // software writes an instruction word to INSTR_OFS; each write is one fetched word

  function automatic logic [7:0] bus_off(input logic [31:0] a);
    return a[7:0];
  endfunction

  function automatic logic zero_of(input logic [7:0] v);
    return v == 8'h00;
  endfunction

  file_port_if fp();
  file_store u_store (.hclk(hclk), .hresetn(hresetn), .fp(fp));

  logic [7:0] acc, next_acc;
  logic [2:0] status, next_status;
  logic [12:0] pc, next_pc;
  logic [7:0] latch, next_latch;
  logic [6:0] file_addr, next_file_addr;
  logic flush, next_flush;
  logic kick;
  logic [WDOG_COUNT_W-1:0] wd_count;
  logic [WDOG_PRESCALE_W-1:0] wd_prescale;

  watchdog_stub u_wdog (
    .hclk(hclk),
    .hresetn(hresetn),
    .kick(kick),
    .count(wd_count),
    .prescale(wd_prescale)
  );

  // bus address phase capture
  logic wr_pend, next_wr_pend;
  logic rd_pend, next_rd_pend;
  logic [7:0] ph_off, next_ph_off;
  logic [31:0] rdata, next_rdata;
  logic phase_ok;

  assign phase_ok = hsel && hready && htrans[1] && (hsize == 3'h2);

  always_comb begin
    next_wr_pend = phase_ok && hwrite;
    next_rd_pend = phase_ok && !hwrite;
    next_ph_off = phase_ok ? bus_off(haddr) : ph_off;
  end

  // instruction execution
  // an enum keeps the execute case unique although opcode fields overlap
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_INVERT = 4'h1,
    OP_DECR = 4'h2,
    OP_DECR_SKIP = 4'h3,
    OP_INCR = 4'h4,
    OP_INCR_SKIP = 4'h5,
    OP_OR_LIT = 4'h6,
    OP_KICK = 4'h7,
    OP_JUMP = 4'h8
  } op_kind_t;

  // codes outside the subset decode to OP_NONE and only advance the pc
  function automatic op_kind_t decode_op(input logic [13:0] w);
    op_kind_t k;
    k = OP_NONE;
    if (w == KICK_WORD) begin
      k = OP_KICK;
    end else if (w[13:11] == JUMP_CODE) begin
      k = OP_JUMP;
    end else begin
      unique case (w[13:8])
        INVERT_CODE: k = OP_INVERT;
        DECR_CODE: k = OP_DECR;
        DECR_SKIP_CODE: k = OP_DECR_SKIP;
        INCR_CODE: k = OP_INCR;
        INCR_SKIP_CODE: k = OP_INCR_SKIP;
        OR_LIT_CODE: k = OP_OR_LIT;
        default: k = OP_NONE;
      endcase
    end
    return k;
  endfunction

  function automatic logic [31:0] pad8(input logic [7:0] v);
    return {24'h000000, v};
  endfunction

  logic exec_en;
  logic [13:0] word;
  logic [7:0] fval, res, lit;
  logic dest_file, upd_zero, skip, is_file, jump;
  logic [12:0] target;
  op_kind_t kind;

  assign exec_en = wr_pend && (ph_off == INSTR_OFS);

  always_comb begin
    // a flushed slot executes as a no-operation; wasted slot costs one extra cycle
    word = flush ? NOP_WORD : hwdata[13:0];
    kind = decode_op(word);
    lit = word[7:0];
    fval = fp.rdata;
    dest_file = word[DEST_BIT];
    res = 8'h00;
    upd_zero = 1'b0;
    skip = 1'b0;
    is_file = 1'b0;
    jump = 1'b0;
    target = pc;
    kick = 1'b0;
    next_acc = acc;
    next_status = status;
    next_latch = latch;
    next_file_addr = file_addr;
    // the file port follows the operand only while an instruction executes
    fp.addr = exec_en ? word[6:0] : file_addr;
    fp.we = 1'b0;
    fp.wdata = 8'h00;
    // instruction words need wr_pend at INSTR_OFS and software writes take the other offsets, so they never meet
    if (exec_en) begin
      if (!flush) begin
        unique case (kind)
          OP_INVERT: begin
            res = ~fval;
            is_file = 1'b1;
            upd_zero = 1'b1;
          end
          OP_DECR: begin
            res = fval - 8'h01;
            is_file = 1'b1;
            upd_zero = 1'b1;
          end
          OP_DECR_SKIP: begin
            res = fval - 8'h01;
            is_file = 1'b1;
            skip = zero_of(res);
          end
          OP_INCR: begin
            res = fval + 8'h01;
            is_file = 1'b1;
            upd_zero = 1'b1;
          end
          OP_INCR_SKIP: begin
            res = fval + 8'h01;
            is_file = 1'b1;
            skip = zero_of(res);
          end
          OP_OR_LIT: begin
            res = acc | lit;
            next_acc = res;
            upd_zero = 1'b1;
          end
          OP_KICK: begin
            kick = 1'b1;
            next_status[EXPIRY_POS] = 1'b1;
            next_status[SLEEP_POS] = 1'b1;
          end
          OP_JUMP: begin
            target = {latch[LATCH_LO+1:LATCH_LO], word[10:0]};
            jump = 1'b1;
          end
          OP_NONE: ;
        endcase
        if (is_file) begin
          if (dest_file) begin
            fp.we = 1'b1;
            fp.wdata = res;
          end else begin
            next_acc = res;
          end
        end
        if (upd_zero) begin
          next_status[ZERO_POS] = zero_of(res);
        end
      end
    end else if (wr_pend) begin
      unique case (ph_off)
        ACC_OFS: next_acc = hwdata[7:0];
        STATUS_OFS: next_status = hwdata[2:0];
        LATCH_OFS: next_latch = hwdata[7:0];
        FILE_ADDR_OFS: next_file_addr = hwdata[6:0];
        FILE_DATA_OFS: begin
          fp.we = 1'b1;
          fp.wdata = hwdata[7:0];
        end
        default: ;
      endcase
    end
  end

  // a taken skip or jump spends the next fetched word as a no-operation
  always_comb begin
    next_pc = pc;
    next_flush = flush;
    if (exec_en) begin
      // the discarded word still held a fetch slot, so the pc steps past it
      next_pc = jump ? target : pc + 13'h0001;
      next_flush = skip || jump;
    end
  end

  // read data stands until the next read completes, so a late sample still sees it
  always_comb begin
    next_rdata = rdata;
    if (rd_pend) begin
      unique case (ph_off)
        ACC_OFS: next_rdata = pad8(acc);
        STATUS_OFS: next_rdata = {29'h0, status};
        PC_OFS: next_rdata = {18'h0, flush, pc};
        LATCH_OFS: next_rdata = pad8(latch);
        FILE_ADDR_OFS: next_rdata = {25'h0, file_addr};
        FILE_DATA_OFS: next_rdata = pad8(fp.rdata);
        WDOG_OFS: next_rdata = {16'h0000, wd_prescale, wd_count};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // software writes land at the end of their data phase, like instruction words
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc <= ACC_RESET;
      status <= STATUS_RESET;
      latch <= LATCH_RESET;
      file_addr <= FILE_ADDR_RESET;
    end else begin
      acc <= next_acc;
      status <= next_status;
      latch <= next_latch;
      file_addr <= next_file_addr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc <= PC_RESET;
      flush <= 1'b0;
    end else begin
      pc <= next_pc;
      flush <= next_flush;
    end
  end

  // an address phase is taken only while hready is high, so a read holds off the next
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      ph_off <= 8'h00;
    end else begin
      wr_pend <= next_wr_pend;
      rd_pend <= next_rd_pend;
      ph_off <= next_ph_off;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  // writes take zero wait states; reads take one, returning data in the second data-phase cycle
  assign hreadyout = !rd_pend;
  assign hresp = 1'b0;
  assign hrdata = rdata;
endmodule // instruction_subset_exec
`default_nettype wire

// ==== bench/exec_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module exec_sva
  import exec_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  assign take = hsel && hready && htrans[1] && hsize == 3'h2;
  sequence rd_wait;
    !hreadyout;
  endsequence
  sequence rd_done;
    hreadyout;
  endsequence
  a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
  a_read_wait: assert property (take && !hwrite |=> rd_wait ##1 rd_done)
    else $error("read wait state wrong");
  a_write_fast: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
  a_no_stall: assert property (!(take && !hwrite) |=> hreadyout) else $error("spurious wait");
  a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved");
  a_unmapped_zero: assert property (take && !hwrite && haddr[7:0] == 8'h20 |=> ##1 hrdata == '0)
    else $error("unmapped read not zero");
  a_acc_bits: assert property (take && !hwrite && haddr[7:0] == ACC_OFS |=> ##1 hrdata[31:8] == '0)
    else $error("accumulator wider than a byte");
  a_status_bits: assert property (take && !hwrite && haddr[7:0] == STATUS_OFS |=> ##1 hrdata[31:3] == '0)
    else $error("status upper bits set");
  a_pc_bits: assert property (take && !hwrite && haddr[7:0] == PC_OFS |=> ##1 hrdata[31:14] == '0)
    else $error("pc upper bits set");
endmodule // exec_sva
bind instruction_subset_exec exec_sva chk(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
  .hready, .hrdata, .hreadyout, .hresp);
`default_nettype wire

// ==== bench/prog_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module prog_mem;
  // fixed program, file operand 0x05; the bench fetches words by index, out of order and some more than once
  logic [13:0] mem [0:10];
  initial begin
    mem[0] = 14'h0905;
    mem[1] = 14'h0985;
    mem[2] = 14'h0A85;
    mem[3] = 14'h0385;
    mem[4] = 14'h0B85;
    mem[5] = 14'h0F05;
    mem[6] = 14'h38FF;
    mem[7] = 14'h3835;
    mem[8] = 14'h3800;
    mem[9] = 14'h2923;
    mem[10] = 14'h0064;
  end
endmodule // prog_mem
`default_nettype wire

// ==== bench/instruction_subset_exec_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CMP(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
  $display("Error t=%0t got %0h exp %0h", $time, (a), (e)); end end
module instruction_subset_exec_test
  import exec_pkg::*;
;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, v;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp;
  int fails = 0, samples_checked = 0;
  always #2 hclk = ~hclk;
  instruction_subset_exec dut(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp);
  prog_mem pm();
  task complete_run;
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // bounded wait so a hung slave ends the run instead of the simulator
  task automatic hold;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      fails++;
      complete_run();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    hold();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    hold();
    v = hrdata;
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    `CMP(v, e)
  endtask
  task automatic x(input int i);
    bus(1'b1, INSTR_OFS, {18'h0, pm.mem[i]});
  endtask
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(ACC_OFS, 32'h0);
    chk(STATUS_OFS, 32'h6);
    chk(8'h20, 32'h0);
    bus(1'b1, FILE_ADDR_OFS, 32'h5);
    bus(1'b1, FILE_DATA_OFS, 32'h13);
    bus(1'b1, STATUS_OFS, 32'h0);
    x(0);
    chk(ACC_OFS, 32'hEC);
    chk(STATUS_OFS, 32'h0);
    bus(1'b1, FILE_DATA_OFS, 32'hFF);
    x(1);
    chk(FILE_DATA_OFS, 32'h0);
    chk(ACC_OFS, 32'hEC);
    chk(STATUS_OFS, 32'h1);
    x(2);
    chk(FILE_DATA_OFS, 32'h1);
    chk(STATUS_OFS, 32'h0);
    x(3);
    chk(FILE_DATA_OFS, 32'h0);
    chk(STATUS_OFS, 32'h1);
    bus(1'b1, FILE_DATA_OFS, 32'hFF);
    x(2);
    chk(FILE_DATA_OFS, 32'h0);
    bus(1'b1, FILE_DATA_OFS, 32'h1);
    bus(1'b1, STATUS_OFS, 32'h0);
    x(4);
    chk(FILE_DATA_OFS, 32'h0);
    chk(STATUS_OFS, 32'h0);
    x(6);
    chk(ACC_OFS, 32'hEC);
    bus(1'b1, FILE_DATA_OFS, 32'hFF);
    x(5);
    chk(ACC_OFS, 32'h0);
    chk(STATUS_OFS, 32'h0);
    x(6);
    chk(ACC_OFS, 32'h0);
    bus(1'b1, FILE_DATA_OFS, 32'h1);
    x(5);
    x(7);
    chk(ACC_OFS, 32'h37);
    bus(1'b1, ACC_OFS, 32'h9A);
    x(7);
    chk(ACC_OFS, 32'hBF);
    bus(1'b1, ACC_OFS, 32'h0);
    x(8);
    chk(STATUS_OFS, 32'h1);
    bus(1'b1, LATCH_OFS, 32'h17);
    bus(1'b1, STATUS_OFS, 32'h0);
    x(9);
    chk(PC_OFS, 32'h3123);
    x(6);
    chk(PC_OFS, 32'h1124);
    chk(STATUS_OFS, 32'h0);
    repeat (300) @(posedge hclk);
    bus(1'b0, WDOG_OFS, '0);
    `CMP(v[7:0] != 8'h00, 1'b1)
    bus(1'b1, STATUS_OFS, 32'h1);
    x(10);
    chk(STATUS_OFS, 32'h7);
    bus(1'b0, WDOG_OFS, '0);
    `CMP(v[7:0], 8'h00)
    `CMP(v[15:8] < 8'h08, 1'b1)
    complete_run();
  end
endmodule // instruction_subset_exec_test
`default_nettype wire
